// ==== hdcfg_regs.sv ====
// hub descriptor configuration register bank with string streaming port
// Notes on behaviour
// - current register is unsigned milliampere count
// - current register resets to 0x64
// - power-on time counts two-millisecond units
// - power-on time only feeds descriptor field
// - language high byte, resets to 0x04
// - language low byte, resets to 0x09
// - maker length register, resets to zero
// - product length register, resets to zero
// - serial length register, resets to zero
// - maker text region, bytes reset zero
// - product text region, bytes reset zero
// - characters stored low byte first
`timescale 1ns/100ps
`include "hdcfg_map.svh"
module hdcfg_regs
  import hdcfg_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire hdcfg_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output hdcfg_desc_t desc_o,
  input wire logic str_start_i,
  input wire logic str_sel_i,
  input wire logic str_ready_i,
  output logic str_valid_o,
  output logic [7:0] str_byte_o,
  output logic str_last_o,
  output logic str_busy_o
);

  hdcfg_state_vec_t s_q;
  hdcfg_state_vec_t s_d;

  function automatic logic [7:0] text_byte(hdcfg_state_vec_t s, logic sel, logic [7:0] idx);
    logic [5:0] i;
    i = idx[5:0];
    if (idx >= 8'(`HD_STR_BYTES)) begin
      text_byte = 8'h00;
    end else if (sel) begin
      text_byte = s.ptext[i];
    end else begin
      text_byte = s.mtext[i];
    end
  endfunction

  // lengths above the region size are cut so the stream never leaves the region
  function automatic logic [7:0] clamp_len(logic [7:0] len);
    clamp_len = (len > 8'(`HD_STR_BYTES)) ? 8'(`HD_STR_BYTES) : len;
  endfunction

  function automatic logic [7:0] reg_read(hdcfg_state_vec_t s, logic [7:0] a);
    reg_read = 8'h00;
    if (a == `HD_OFF_CUR) begin
      reg_read = s.desc.controller_current_value;
    end else if (a == `HD_OFF_PON) begin
      reg_read = s.desc.power_on_to_good_time;
    end else if (a == `HD_OFF_LANG_HI) begin
      reg_read = s.desc.language_code[15:8];
    end else if (a == `HD_OFF_LANG_LO) begin
      reg_read = s.desc.language_code[7:0];
    end else if (a == `HD_OFF_MLEN) begin
      reg_read = s.desc.maker_text_length_value;
    end else if (a == `HD_OFF_PLEN) begin
      reg_read = s.desc.product_text_length_value;
    end else if (a == `HD_OFF_SLEN) begin
      reg_read = s.desc.serial_text_length_value;
    end else if (a >= `HD_MSTR_BASE && a <= `HD_MSTR_LAST) begin
      reg_read = text_byte(s, 1'b0, 8'(a - `HD_MSTR_BASE));
    end else if (a >= `HD_PSTR_BASE && a <= `HD_PSTR_LAST) begin
      reg_read = text_byte(s, 1'b1, 8'(a - `HD_PSTR_BASE));
    end
  endfunction

  always_comb begin
    logic [7:0] len;
    logic [7:0] idx;
    len = 8'h00;
    idx = 8'h00;
    s_d = s_q;
    s_d.rvalid = 1'b0;
    // a read in the same cycle as a write to the same byte returns the old value
    if (bus_i.rd) begin
      s_d.rdata = reg_read(s_q, bus_i.addr);
      s_d.rvalid = 1'b1;
    end
    if (bus_i.wr) begin
      idx = 8'(bus_i.addr - `HD_MSTR_BASE);
      if (bus_i.addr == `HD_OFF_CUR) begin
        s_d.desc.controller_current_value = bus_i.wdata;
      end else if (bus_i.addr == `HD_OFF_PON) begin
        s_d.desc.power_on_to_good_time = bus_i.wdata;
      end else if (bus_i.addr == `HD_OFF_LANG_HI) begin
        s_d.desc.language_code[15:8] = bus_i.wdata;
      end else if (bus_i.addr == `HD_OFF_LANG_LO) begin
        s_d.desc.language_code[7:0] = bus_i.wdata;
      end else if (bus_i.addr == `HD_OFF_MLEN) begin
        s_d.desc.maker_text_length_value = bus_i.wdata;
      end else if (bus_i.addr == `HD_OFF_PLEN) begin
        s_d.desc.product_text_length_value = bus_i.wdata;
      end else if (bus_i.addr == `HD_OFF_SLEN) begin
        s_d.desc.serial_text_length_value = bus_i.wdata;
      end else if (bus_i.addr >= `HD_MSTR_BASE && bus_i.addr <= `HD_MSTR_LAST) begin
        s_d.mtext[idx[5:0]] = bus_i.wdata;
      end else if (bus_i.addr >= `HD_PSTR_BASE && bus_i.addr <= `HD_PSTR_LAST) begin
        idx = 8'(bus_i.addr - `HD_PSTR_BASE);
        s_d.ptext[idx[5:0]] = bus_i.wdata;
      end
    end
    unique case (s_q.st)
      HDCFG_IDLE: begin
        if (str_start_i) begin
          len = clamp_len(str_sel_i ? s_q.desc.product_text_length_value :
                                      s_q.desc.maker_text_length_value);
          if (len != 8'h00) begin
            s_d.st = HDCFG_SEND;
            s_d.sel = str_sel_i;
            s_d.total = len;
            s_d.cnt = 8'h00;
            s_d.sbyte = text_byte(s_q, str_sel_i, 8'h00);
          end
        end
      end
      HDCFG_SEND: begin
        if (str_ready_i) begin
          if (s_q.cnt == 8'(s_q.total - 8'h01)) begin
            s_d.st = HDCFG_IDLE;
          end else begin
            s_d.cnt = 8'(s_q.cnt + 8'h01);
            s_d.sbyte = text_byte(s_q, s_q.sel, 8'(s_q.cnt + 8'h01));
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.desc.controller_current_value <= `HD_RST_CUR;
      s_q.desc.power_on_to_good_time <= `HD_RST_PON;
      s_q.desc.language_code <= {`HD_RST_LANG_HI, `HD_RST_LANG_LO};
      s_q.desc.maker_text_length_value <= `HD_RST_LEN;
      s_q.desc.product_text_length_value <= `HD_RST_LEN;
      s_q.desc.serial_text_length_value <= `HD_RST_LEN;
      s_q.mtext <= {`HD_STR_BYTES{`HD_RST_STR}};
      s_q.ptext <= {`HD_STR_BYTES{`HD_RST_STR}};
      s_q.st <= HDCFG_IDLE;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign rvalid_o = s_q.rvalid;
  assign desc_o = s_q.desc;
  assign str_valid_o = (s_q.st == HDCFG_SEND);
  assign str_byte_o = s_q.sbyte;
  assign str_last_o = (s_q.st == HDCFG_SEND) && (s_q.cnt == 8'(s_q.total - 8'h01));
  assign str_busy_o = (s_q.st == HDCFG_SEND);

  property p_reset_values;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> desc_o.controller_current_value == 8'h64 &&
        desc_o.language_code == 16'h0409 && desc_o.maker_text_length_value == 8'h00 &&
        desc_o.product_text_length_value == 8'h00 && desc_o.serial_text_length_value == 8'h00;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset value");

  property p_text_reset;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> s_q.mtext == '0 && s_q.ptext == '0;
  endproperty
  a_text_reset: assert property (p_text_reset) else $error("text not cleared");

  property p_cur_write;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && bus_i.wr && bus_i.addr == 8'h0f |=>
        desc_o.controller_current_value == $past(bus_i.wdata);
  endproperty
  a_cur_write: assert property (p_cur_write) else $error("current not written");

  property p_pon_only;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && bus_i.wr && bus_i.addr == `HD_OFF_PON && !str_busy_o && !str_start_i |=>
        desc_o.power_on_to_good_time == $past(bus_i.wdata) && $stable(desc_o.language_code) &&
        $stable(s_q.mtext) && $stable(s_q.st);
  endproperty
  a_pon_only: assert property (p_pon_only) else $error("power-on time misbehaves");

  property p_lang_high;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && bus_i.wr && bus_i.addr == 8'h11 |=>
        desc_o.language_code[15:8] == $past(bus_i.wdata) && $stable(desc_o.language_code[7:0]);
  endproperty
  a_lang_high: assert property (p_lang_high) else $error("language high byte wrong");

  property p_stream_bound;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      str_valid_o |-> s_q.cnt < s_q.total && s_q.total <= 8'd62;
  endproperty
  a_stream_bound: assert property (p_stream_bound) else $error("stream past region");

  property p_stream_end;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && str_valid_o && str_ready_i && str_last_o |=> !str_valid_o;
  endproperty
  a_stream_end: assert property (p_stream_end) else $error("stream overran length");

  property p_stream_byte;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && str_valid_o && !s_q.sel && str_ready_i && !str_last_o && !bus_i.wr |=>
        str_byte_o == s_q.mtext[s_q.cnt[5:0]] && s_q.cnt == $past(s_q.cnt) + 8'd1;
  endproperty
  a_stream_byte: assert property (p_stream_byte) else $error("stream byte out of order");

  property p_read_clean;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && bus_i.rd && !bus_i.wr |=> rvalid_o && $stable(desc_o) && $stable(s_q.ptext);
  endproperty
  a_read_clean: assert property (p_read_clean) else $error("read had side effect");

  property p_lang_low;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && bus_i.wr && bus_i.addr == `HD_OFF_LANG_LO |=>
        desc_o.language_code[7:0] == $past(bus_i.wdata) && $stable(desc_o.language_code[15:8]);
  endproperty
  a_lang_low: assert property (p_lang_low) else $error("language low byte wrong");

  property p_maker_len;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && bus_i.wr && bus_i.addr == `HD_OFF_MLEN |=>
        desc_o.maker_text_length_value == $past(bus_i.wdata);
  endproperty
  a_maker_len: assert property (p_maker_len) else $error("maker length not written");

  property p_product_len;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && bus_i.wr && bus_i.addr == `HD_OFF_PLEN |=>
        desc_o.product_text_length_value == $past(bus_i.wdata);
  endproperty
  a_product_len: assert property (p_product_len) else $error("product length not written");

  property p_serial_len;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && bus_i.wr && bus_i.addr == `HD_OFF_SLEN |=>
        desc_o.serial_text_length_value == $past(bus_i.wdata);
  endproperty
  a_serial_len: assert property (p_serial_len) else $error("serial length not written");

  property p_maker_text;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && bus_i.wr && bus_i.addr >= `HD_MSTR_BASE && bus_i.addr <= `HD_MSTR_LAST |=>
        s_q.mtext[6'($past(bus_i.addr) - `HD_MSTR_BASE)] == $past(bus_i.wdata);
  endproperty
  a_maker_text: assert property (p_maker_text) else $error("maker text byte not stored");

  property p_product_text;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && bus_i.wr && bus_i.addr >= `HD_PSTR_BASE && bus_i.addr <= `HD_PSTR_LAST |=>
        s_q.ptext[6'($past(bus_i.addr) - `HD_PSTR_BASE)] == $past(bus_i.wdata);
  endproperty
  a_product_text: assert property (p_product_text) else $error("product text not stored");

  property p_product_byte;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && str_valid_o && s_q.sel && str_ready_i && !str_last_o && !bus_i.wr |=>
        str_byte_o == s_q.ptext[s_q.cnt[5:0]] && s_q.cnt == $past(s_q.cnt) + 8'd1;
  endproperty
  a_product_byte: assert property (p_product_byte) else $error("product byte out of order");

  property p_stream_empty;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && !str_busy_o && str_start_i && !str_sel_i &&
        desc_o.maker_text_length_value == 8'h00 |=> !str_valid_o;
  endproperty
  a_stream_empty: assert property (p_stream_empty) else $error("empty string streamed");

  property p_stream_first;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && !str_busy_o && str_start_i && !str_sel_i && !bus_i.wr &&
        desc_o.maker_text_length_value != 8'h00 |=> str_valid_o && str_byte_o == s_q.mtext[0];
  endproperty
  a_stream_first: assert property (p_stream_first) else $error("stream start wrong");

  property p_read_pulse;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && !bus_i.rd |=> !rvalid_o;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read answer without read");

  property p_freeze;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      !ce_i |=> $stable(desc_o) && $stable(rvalid_o) && $stable(s_q.st) && $stable(s_q.mtext);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  c_stream_done: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    str_valid_o && str_last_o && str_ready_i && ce_i);
  c_product_stream: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    str_valid_o && s_q.sel);
  c_write_read: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && bus_i.wr ##1 ce_i && bus_i.rd ##1 rvalid_o);
  c_empty_start: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && str_start_i && !str_busy_o && desc_o.maker_text_length_value == 8'h00);
  c_frozen_write: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !ce_i && bus_i.wr);

endmodule

// ==== hdcfg_map.svh ====
// offsets, region bounds and reset values of the hub descriptor configuration bank
`ifndef HDCFG_MAP_SVH
`define HDCFG_MAP_SVH
`define HD_OFF_CUR 8'h0f
`define HD_OFF_PON 8'h10
`define HD_OFF_LANG_HI 8'h11
`define HD_OFF_LANG_LO 8'h12
`define HD_OFF_MLEN 8'h13
`define HD_OFF_PLEN 8'h14
`define HD_OFF_SLEN 8'h15
`define HD_MSTR_BASE 8'h16
`define HD_MSTR_LAST 8'h53
`define HD_PSTR_BASE 8'h54
`define HD_PSTR_LAST 8'h91
`define HD_STR_BYTES 62
`define HD_RST_CUR 8'h64
`define HD_RST_PON 8'h00
`define HD_RST_LANG_HI 8'h04
`define HD_RST_LANG_LO 8'h09
`define HD_RST_LEN 8'h00
`define HD_RST_STR 8'h00
`endif

// ==== hdcfg_pkg.sv ====
// types shared by the hub descriptor configuration bank
`include "hdcfg_map.svh"
package hdcfg_pkg;
  typedef enum logic {HDCFG_IDLE, HDCFG_SEND} hdcfg_state_t;
  typedef logic [`HD_STR_BYTES-1:0][7:0] hdcfg_text_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hdcfg_bus_req_t;
  typedef struct packed {
    logic [7:0] controller_current_value;
    logic [7:0] power_on_to_good_time;
    logic [15:0] language_code;
    logic [7:0] maker_text_length_value;
    logic [7:0] product_text_length_value;
    logic [7:0] serial_text_length_value;
  } hdcfg_desc_t;
  typedef struct packed {
    hdcfg_desc_t desc;
    hdcfg_text_t mtext;
    hdcfg_text_t ptext;
    logic [7:0] rdata;
    logic rvalid;
    hdcfg_state_t st;
    logic sel;
    logic [7:0] cnt;
    logic [7:0] total;
    logic [7:0] sbyte;
  } hdcfg_state_vec_t;
endpackage

// ==== hdcfg_sink.sv ====
// descriptor-side consumer model for the string stream port
`timescale 1ns/100ps
module hdcfg_sink (
  input wire logic ref_clk_i,
  input wire logic valid_i,
  input wire logic [7:0] byte_i,
  input wire logic last_i,
  output logic ready_o
);
  logic [7:0] got[$];
  logic lst[$];
  initial ready_o = 1'b0;
  // random stalls make the block hold each byte until it is taken
  always @(posedge ref_clk_i) begin
    if (valid_i && ready_o) begin
      got.push_back(byte_i);
      lst.push_back(last_i);
    end
    ready_o <= ($urandom % 3) != 0;
  end
endmodule

// ==== tb_top.sv ====
// self-checking bench for the hub descriptor configuration bank
`timescale 1ns/100ps
`include "hdcfg_map.svh"
module tb_top;
  import hdcfg_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  hdcfg_bus_req_t bus = '0;
  logic str_start = 1'b0;
  logic str_sel = 1'b0;
  logic [7:0] rdata;
  logic [7:0] sbyte;
  logic rvalid, svalid, slast, sbusy, sready;
  hdcfg_desc_t desc;
  int m[256];
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int lens[7] = '{0, 1, 2, 7, 62, 63, 200};
  always #4 ref_clk_i = ~ref_clk_i;
  hdcfg_regs i_hdcfg_regs (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .bus_i(bus),
    .rdata_o(rdata), .rvalid_o(rvalid), .desc_o(desc), .str_start_i(str_start),
    .str_sel_i(str_sel), .str_ready_i(sready), .str_valid_o(svalid), .str_byte_o(sbyte),
    .str_last_o(slast), .str_busy_o(sbusy));
  hdcfg_sink i_hdcfg_sink (.ref_clk_i(ref_clk_i), .valid_i(svalid), .byte_i(sbyte),
    .last_i(slast), .ready_o(sready));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic [55:0] exp_desc();
    return {8'(m[15]), 8'(m[16]), 8'(m[17]), 8'(m[18]), 8'(m[19]), 8'(m[20]), 8'(m[21])};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk_i) bus <= '0;
    // unmapped places keep nothing, so the model only stores mapped ones
    if (a >= `HD_OFF_CUR && a <= `HD_PSTR_LAST) m[a] = d;
  endtask
  task automatic rd_chk(input logic [7:0] a);
    @(posedge ref_clk_i) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk_i) bus <= '0;
    #1;
    chk({rvalid, rdata}, {1'b1, 8'(m[a])}, "read");
  endtask
  task automatic regs_chk();
    #1;
    chk(64'(desc), 64'(exp_desc()), "desc");
    for (int a = 'h0e; a <= 'h92; a++) rd_chk(8'(a));
    rd_chk(8'hff);
  endtask
  task automatic stream(input logic s, input int len);
    int n;
    int base;
    n = (len > `HD_STR_BYTES) ? `HD_STR_BYTES : len;
    base = s ? `HD_PSTR_BASE : `HD_MSTR_BASE;
    i_hdcfg_sink.got.delete();
    i_hdcfg_sink.lst.delete();
    @(posedge ref_clk_i) begin
      str_start <= 1'b1;
      str_sel <= s;
    end
    @(posedge ref_clk_i) str_start <= 1'b0;
    #1;
    for (int i = 0; i < 600 && sbusy === 1'b1; i++) begin
      @(posedge ref_clk_i);
      #1;
    end
    repeat (2) @(posedge ref_clk_i);
    chk(i_hdcfg_sink.got.size(), n, "count");
    chk(sbusy, 1'b0, "idle");
    for (int i = 0; i < n; i++) begin
      chk(i_hdcfg_sink.got[i], m[base + i], "byte");
      chk(i_hdcfg_sink.lst[i], i == n - 1, "last");
    end
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'h5a2c));
    for (int a = 0; a < 256; a++) m[a] = 0;
    m[`HD_OFF_CUR] = 'h64;
    m[`HD_OFF_LANG_HI] = 'h04;
    m[`HD_OFF_LANG_LO] = 'h09;
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    regs_chk();
    $display("test reset values done");
    for (int a = 'h0e; a <= 'h92; a++) wr(8'(a), 8'($urandom));
    wr(8'hff, 8'h5a);
    regs_chk();
    $display("test write readback done");
    wr(`HD_OFF_PON, 8'h00);
    @(posedge ref_clk_i) ce_i <= 1'b0;
    @(posedge ref_clk_i) bus <= '{wr: 1'b1, rd: 1'b0, addr: `HD_OFF_CUR,
                                  wdata: 8'(~m[`HD_OFF_CUR])};
    @(posedge ref_clk_i) bus <= '0;
    @(posedge ref_clk_i) ce_i <= 1'b1;
    #1;
    chk(64'(desc), 64'(exp_desc()), "frozen");
    $display("test clock enable done");
    for (int i = 0; i < 7; i++) begin
      wr(i[0] ? `HD_OFF_PLEN : `HD_OFF_MLEN, 8'(lens[i]));
      stream(i[0], lens[i]);
    end
    $display("test string streams done");
    end_of_test();
  end
endmodule
